// [hw/bcr_pkg.sv]
// package: register indices, field positions and reset values of the banked core registers
package bcr_pkg;
  localparam logic [8:0] IDX_INDIRECT_B2 = 9'h100;
  localparam logic [8:0] IDX_TIMER_ZERO = 9'h101;
  localparam logic [8:0] IDX_COUNTER_LOW_B2 = 9'h102;
  localparam logic [8:0] IDX_FLAGS_B2 = 9'h103;
  localparam logic [8:0] IDX_POINTER_B2 = 9'h104;
  localparam logic [8:0] IDX_PORT_TWO_LATCH = 9'h106;
  localparam logic [8:0] IDX_UPPER_BUF_B2 = 9'h10a;
  localparam logic [8:0] IDX_IRQ_CTRL_B2 = 9'h10b;
  localparam logic [8:0] IDX_INDIRECT_B3 = 9'h180;
  localparam logic [8:0] IDX_PRESCALE_OPTS = 9'h181;
  localparam logic [8:0] IDX_COUNTER_LOW_B3 = 9'h182;
  localparam logic [8:0] IDX_FLAGS_B3 = 9'h183;
  localparam logic [8:0] IDX_POINTER_B3 = 9'h184;
  localparam logic [8:0] IDX_PORT_TWO_DIR = 9'h186;
  localparam logic [8:0] IDX_UPPER_BUF_B3 = 9'h18a;
  localparam logic [8:0] IDX_IRQ_CTRL_B3 = 9'h18b;
  // low seven bits of the shared core registers, mirrored in every bank
  localparam logic [6:0] OFS_INDIRECT = 7'h00;
  localparam logic [6:0] OFS_COUNTER_LOW = 7'h02;
  localparam logic [6:0] OFS_FLAGS = 7'h03;
  localparam logic [6:0] OFS_POINTER = 7'h04;
  localparam logic [6:0] OFS_UPPER_BUF = 7'h0a;
  localparam logic [6:0] OFS_IRQ_CTRL = 7'h0b;
  // flag register bit positions
  localparam int BIT_CARRY = 0;
  localparam int BIT_NIBBLE_CARRY = 1;
  localparam int BIT_ZERO = 2;
  localparam int BIT_SLEEP = 3;
  localparam int BIT_TIMEOUT = 4;
  localparam int BIT_BANK_LOW = 5;
  localparam int BIT_BANK_HIGH = 6;
  localparam int BIT_INDIRECT_BANK = 7;
  localparam logic [7:0] ALU_FLAG_MASK = 8'h07;
  localparam logic [7:0] RESET_FLAG_MASK = 8'h18;
  localparam logic [7:0] BANK_FLAG_MASK = 8'he0;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ONES = 8'hff;
  localparam logic [7:0] RST_FLAGS_POR = 8'h18;
  localparam logic [7:0] RST_PORT_TWO_LATCH = 8'h0c;
  localparam logic [4:0] RST_UPPER_BUF = 5'h00;
  localparam logic [12:0] RST_PC = 13'h0000;
  typedef enum logic [1:0] {
    BCR_RST_NONE = 2'b00,
    BCR_RST_POWER = 2'b01,
    BCR_RST_OTHER = 2'b10
  } bcr_rst_kind_t;
endpackage

// [hw/bcr_pc_if.sv]
// interface: counter low byte and upper buffer traffic between core regs and counter
`timescale 1ns/100ps
interface bcr_pc_if;
  logic wr_low;
  logic [7:0] wr_data;
  logic load_full;
  logic [12:0] load_value;
  logic step;
  logic [4:0] upper_buf;
  logic [12:0] pc;
  modport regs (output wr_low, output wr_data, output upper_buf, input pc);
  modport counter (input wr_low, input wr_data, input upper_buf, input load_full,
    input load_value, input step, output pc);
  modport core (output load_full, output load_value, output step);
endinterface

// [hw/bcr_prog_counter.sv]
// program counter: low byte write loads upper part from the write buffer
`timescale 1ns/100ps
module bcr_prog_counter (
  input wire logic clk,
  input wire logic sys_rst,
  bcr_pc_if.counter pcb
);
  typedef struct packed {
    logic [12:0] pc;
  } bcr_pc_state_t;
  bcr_pc_state_t st_q;
  bcr_pc_state_t st_d;

  // a direct low byte write takes the upper bits from the buffer; a jump loads the full load_value
  always_comb begin
    st_d = st_q;
    if (pcb.wr_low) begin
      st_d.pc = {pcb.upper_buf, pcb.wr_data};
    end else if (pcb.load_full) begin
      st_d.pc = pcb.load_value;
    end else if (pcb.step) begin
      st_d.pc = 13'(st_q.pc + 13'h0001);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q.pc <= bcr_pkg::RST_PC;
    end else begin
      st_q <= st_d;
    end
  end

  assign pcb.pc = st_q.pc;
endmodule // bcr_prog_counter

// [hw/bcr_flag_unit.sv]
// flag register: protected reset flags, alu flag override, clear behaviour
`timescale 1ns/100ps
module bcr_flag_unit (
  input wire logic clk,
  input wire logic sys_rst,
  input wire bcr_pkg::bcr_rst_kind_t rst_kind,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic alu_upd,
  input wire logic [2:0] alu_flags,
  input wire logic [2:0] alu_flag_sel,
  input wire logic sleep_enter,
  input wire logic wdt_clear,
  input wire logic wdt_timeout,
  output logic [7:0] flags
);
  typedef struct packed {
    logic [7:0] f;
  } bcr_flag_state_t;
  bcr_flag_state_t st_q;
  bcr_flag_state_t st_d;
  logic [7:0] alu_mask;

  always_comb begin
    alu_mask = {5'h00, alu_flag_sel};
    st_d = st_q;
    // software reaches only bank and alu bits; reset flags never take data
    if (wr_en) begin
      st_d.f = (st_q.f & bcr_pkg::RESET_FLAG_MASK) | (wr_data & ~bcr_pkg::RESET_FLAG_MASK);
      if (alu_upd) begin
        st_d.f = (st_d.f & ~alu_mask) | (st_q.f & alu_mask);
      end
    end
    // alu result wins over the data write for the flags it computes
    if (alu_upd) begin
      st_d.f = (st_d.f & ~alu_mask) | ({5'h00, alu_flags} & alu_mask);
    end
    if (sleep_enter) begin
      st_d.f[bcr_pkg::BIT_SLEEP] = 1'b0;
      st_d.f[bcr_pkg::BIT_TIMEOUT] = 1'b1;
    end else if (wdt_clear) begin
      st_d.f[bcr_pkg::BIT_SLEEP] = 1'b1;
      st_d.f[bcr_pkg::BIT_TIMEOUT] = 1'b1;
    end
    if (wdt_timeout) begin
      st_d.f[bcr_pkg::BIT_TIMEOUT] = 1'b0;
    end
  end

  // other resets keep alu flags and reset flags, clear bank bits
  always_ff @(posedge clk) begin
    if (sys_rst || rst_kind == bcr_pkg::BCR_RST_POWER) begin
      st_q.f <= bcr_pkg::RST_FLAGS_POR;
    end else if (rst_kind == bcr_pkg::BCR_RST_OTHER) begin
      st_q.f <= st_q.f & ~bcr_pkg::BANK_FLAG_MASK;
    end else begin
      st_q <= st_d;
    end
  end

  assign flags = st_q.f;
endmodule // bcr_flag_unit

// [hw/bcr_core_regs.sv]
// banked core registers for banks 2 and 3 with shared core registers
// How it works
// - unmapped locations read zero, writes ignored
// - only counter low byte is register-visible
// - five-bit upper buffer loads counter upper part
// - pin and watchdog resets keep marked fields
// - shared core registers identical across four banks
// - SMALL_PACKAGE parameter is unused; port two reads the same in every build
// - flags hold alu, reset cause, bank bits
// - alu-updated flags ignore the data write
// - timeout and sleep flags ignore writes
// - clear op zeros bank bits, sets zero
// - subtract carry flags are inverted borrows
`timescale 1ns/100ps
module bcr_core_regs #(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic external_reset_pin,
  input wire logic power_up_rst,
  input wire logic wdt_timeout,
  input wire logic wdt_clear,
  input wire logic sleep_enter,
  input wire logic indirect,
  input wire logic [6:0] operand,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic rd_hit,
  output logic [8:0] reg_index,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic clear_op,
  input wire logic alu_upd,
  input wire logic [2:0] alu_flag_sel,
  input wire logic alu_sub,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  output logic [7:0] alu_result,
  input wire logic pc_load,
  input wire logic [12:0] pc_load_value,
  input wire logic pc_step,
  output logic [12:0] pc,
  input wire logic [7:0] port_two_pins,
  input wire logic [7:0] timer_zero_in,
  input wire logic timer_zero_tick,
  output logic [7:0] port_two_latch,
  output logic [7:0] port_two_dir,
  output logic [7:0] prescale_opts,
  output logic [7:0] irq_ctrl,
  output logic [7:0] flags
);
  typedef struct packed {
    logic [7:0] timer;
    logic [7:0] pointer;
    logic [7:0] latch;
    logic [4:0] upper_buf;
    logic [7:0] irq;
    logic [7:0] opts;
    logic [7:0] dir;
    bcr_pkg::bcr_rst_kind_t rst_kind;
  } bcr_state_t;

  bcr_state_t st_q;
  bcr_state_t st_d;
  bcr_pc_if pcb ();
  logic [8:0] idx;
  logic [8:0] alu_sum;
  logic [4:0] alu_nib;
  logic [2:0] alu_flags;
  logic [7:0] flag_wr;
  logic flag_wr_en;
  logic counter_wr;
  logic [7:0] rd_mux;
  logic hit;

  // shared core register seen through any bank
  function automatic logic is_shared(input logic [8:0] i, input logic [6:0] ofs);
    return i[6:0] == ofs;
  endfunction

  // direct index joins bank bits with operand; indirect uses pointer and its bank bit
  always_comb begin
    if (indirect) begin
      idx = {flags[bcr_pkg::BIT_INDIRECT_BANK], st_q.pointer};
    end else begin
      idx = {flags[bcr_pkg::BIT_BANK_HIGH], flags[bcr_pkg::BIT_BANK_LOW], operand};
    end
  end

  // alu: subtraction adds the two's complement, so carries become inverted borrows
  always_comb begin
    if (alu_sub) begin
      alu_sum = 9'({1'b0, alu_a} + {1'b0, ~alu_b} + 9'h001);
      alu_nib = 5'({1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} + 5'h01);
    end else begin
      alu_sum = 9'({1'b0, alu_a} + {1'b0, alu_b});
      alu_nib = 5'({1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]});
    end
    alu_flags = {alu_sum[7:0] == 8'h00, alu_nib[4], alu_sum[8]};
  end
  assign alu_result = alu_sum[7:0];

  // read decode; the counter upper byte has no location of its own
  always_comb begin
    rd_mux = 8'h00;
    hit = 1'b1;
    if (is_shared(idx, bcr_pkg::OFS_INDIRECT)) begin
      rd_mux = 8'h00; // indirect through the pointer to itself reads zero
    end else if (is_shared(idx, bcr_pkg::OFS_COUNTER_LOW)) begin
      rd_mux = pcb.pc[7:0];
    end else if (is_shared(idx, bcr_pkg::OFS_FLAGS)) begin
      rd_mux = flags;
    end else if (is_shared(idx, bcr_pkg::OFS_POINTER)) begin
      rd_mux = st_q.pointer;
    end else if (is_shared(idx, bcr_pkg::OFS_UPPER_BUF)) begin
      rd_mux = {3'h0, st_q.upper_buf};
    end else if (is_shared(idx, bcr_pkg::OFS_IRQ_CTRL)) begin
      rd_mux = st_q.irq;
    end else begin
      case (idx)
        bcr_pkg::IDX_TIMER_ZERO: rd_mux = st_q.timer;
        bcr_pkg::IDX_PORT_TWO_LATCH: rd_mux = port_two_pins;
        bcr_pkg::IDX_PRESCALE_OPTS: rd_mux = st_q.opts;
        bcr_pkg::IDX_PORT_TWO_DIR: rd_mux = st_q.dir;
        default: begin
          rd_mux = 8'h00;
          hit = 1'b0;
        end
      endcase
    end
    // only banks 2 and 3 are local apart from the shared registers
    if (!idx[8] && hit && !(is_shared(idx, bcr_pkg::OFS_INDIRECT)
        || is_shared(idx, bcr_pkg::OFS_COUNTER_LOW) || is_shared(idx, bcr_pkg::OFS_FLAGS)
        || is_shared(idx, bcr_pkg::OFS_POINTER) || is_shared(idx, bcr_pkg::OFS_UPPER_BUF)
        || is_shared(idx, bcr_pkg::OFS_IRQ_CTRL))) begin
      rd_mux = 8'h00;
      hit = 1'b0;
    end
  end

  // read data is zero unless rd_en; SMALL_PACKAGE does not change the read path
  assign rd_data = rd_en ? rd_mux : 8'h00;
  assign rd_hit = rd_en & hit;
  assign reg_index = idx;

  // flag writes: clear op zeros bank bits, carries write back their own value so
  // they stay put, zero flag is forced through the alu path
  always_comb begin
    flag_wr_en = (wr_en || clear_op) && is_shared(idx, bcr_pkg::OFS_FLAGS);
    flag_wr = clear_op ? (flags & bcr_pkg::ALU_FLAG_MASK) : wr_data;
  end

  bcr_flag_unit u_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .rst_kind(st_q.rst_kind),
    .wr_en(flag_wr_en),
    .wr_data(flag_wr),
    .alu_upd(alu_upd || clear_op),
    .alu_flags(clear_op ? 3'b100 : alu_flags),
    .alu_flag_sel(clear_op ? 3'b100 : alu_flag_sel),
    .sleep_enter(sleep_enter),
    .wdt_clear(wdt_clear),
    .wdt_timeout(wdt_timeout),
    .flags(flags)
  );

  assign counter_wr = wr_en && hit && is_shared(idx, bcr_pkg::OFS_COUNTER_LOW);
  // a pending reset of either kind reloads the counter; it beats any write that cycle
  assign pcb.wr_low = counter_wr && st_q.rst_kind == bcr_pkg::BCR_RST_NONE;
  assign pcb.wr_data = wr_data;
  assign pcb.upper_buf = st_q.upper_buf;
  assign pcb.load_full = pc_load || st_q.rst_kind != bcr_pkg::BCR_RST_NONE;
  assign pcb.load_value = (st_q.rst_kind != bcr_pkg::BCR_RST_NONE) ? bcr_pkg::RST_PC
    : pc_load_value;
  assign pcb.step = pc_step;

  bcr_prog_counter u_pc (
    .clk(clk),
    .sys_rst(sys_rst),
    .pcb(pcb)
  );

  // register writes and reset classification
  always_comb begin
    st_d = st_q;
    if (power_up_rst) begin
      st_d.rst_kind = bcr_pkg::BCR_RST_POWER;
    end else if (external_reset_pin || wdt_timeout) begin
      st_d.rst_kind = bcr_pkg::BCR_RST_OTHER;
    end else begin
      st_d.rst_kind = bcr_pkg::BCR_RST_NONE;
    end
    if (timer_zero_tick) begin
      st_d.timer = timer_zero_in;
    end
    if (wr_en && hit) begin
      if (is_shared(idx, bcr_pkg::OFS_POINTER)) begin
        st_d.pointer = wr_data;
      end else if (is_shared(idx, bcr_pkg::OFS_UPPER_BUF)) begin
        st_d.upper_buf = wr_data[4:0];
      end else if (is_shared(idx, bcr_pkg::OFS_IRQ_CTRL)) begin
        st_d.irq = wr_data;
      end else begin
        case (idx)
          bcr_pkg::IDX_TIMER_ZERO: st_d.timer = wr_data;
          bcr_pkg::IDX_PORT_TWO_LATCH: st_d.latch = wr_data;
          bcr_pkg::IDX_PRESCALE_OPTS: st_d.opts = wr_data;
          bcr_pkg::IDX_PORT_TWO_DIR: st_d.dir = wr_data;
          default: st_d.latch = st_q.latch;
        endcase
      end
    end
    // power-up and other resets: values from the reset column
    if (st_q.rst_kind != bcr_pkg::BCR_RST_NONE) begin
      st_d.upper_buf = bcr_pkg::RST_UPPER_BUF;
      st_d.irq = {7'h00, st_q.irq[0]};
      st_d.opts = bcr_pkg::RST_ONES;
      st_d.dir = bcr_pkg::RST_ONES;
      st_d.latch = (st_q.latch & ~bcr_pkg::RST_PORT_TWO_LATCH) | bcr_pkg::RST_PORT_TWO_LATCH;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q.timer <= bcr_pkg::RST_ZERO;
      st_q.pointer <= bcr_pkg::RST_ZERO;
      st_q.latch <= bcr_pkg::RST_PORT_TWO_LATCH;
      st_q.upper_buf <= bcr_pkg::RST_UPPER_BUF;
      st_q.irq <= bcr_pkg::RST_ZERO;
      st_q.opts <= bcr_pkg::RST_ONES;
      st_q.dir <= bcr_pkg::RST_ONES;
      st_q.rst_kind <= bcr_pkg::BCR_RST_NONE;
    end else begin
      st_q <= st_d;
    end
  end

  assign pc = pcb.pc;
  assign port_two_latch = st_q.latch;
  assign port_two_dir = st_q.dir;
  assign prescale_opts = st_q.opts;
  assign irq_ctrl = st_q.irq;
endmodule // bcr_core_regs

// [test/bcr_core_regs_chk.sv]
// checker: port timing of the banked core register block
`timescale 1ns/100ps
module bcr_core_regs_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic external_reset_pin,
  input wire logic power_up_rst,
  input wire logic wdt_timeout,
  input wire logic wdt_clear,
  input wire logic sleep_enter,
  input wire logic indirect,
  input wire logic [6:0] operand,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic rd_hit,
  input wire logic [8:0] reg_index,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic clear_op,
  input wire logic alu_upd,
  input wire logic [2:0] alu_flag_sel,
  input wire logic alu_sub,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic [7:0] alu_result,
  input wire logic pc_load,
  input wire logic pc_step,
  input wire logic [12:0] pc,
  input wire logic [7:0] prescale_opts,
  input wire logic [7:0] flags
);
  // any event allowed to move the reset-cause flags
  wire logic ev = external_reset_pin | wdt_timeout | power_up_rst | wdt_clear | sleep_enter;
  wire logic at_flags = reg_index[6:0] == bcr_pkg::OFS_FLAGS;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_buf_wr;
    wr_en && reg_index[6:0] == bcr_pkg::OFS_UPPER_BUF && !ev && !$past(ev);
  endsequence
  sequence s_low_wr;
    wr_en && reg_index[6:0] == bcr_pkg::OFS_COUNTER_LOW && !ev && !pc_load && !pc_step;
  endsequence
  property p_pc_upper;
    s_buf_wr ##1 s_low_wr |=> pc == {$past(wr_data[4:0], 2), $past(wr_data)};
  endproperty
  AST_UNMAPPED_ZERO: assert property (
    rd_en && !rd_hit |-> rd_data == 8'h00) else $error("unmapped read not zero");
  AST_DIRECT_INDEX: assert property (
    !indirect |-> reg_index == {flags[6:5], operand}) else $error("bad direct index");
  AST_RESET_FLAGS_HELD: assert property (
    $changed(flags[4:3]) |-> $past(ev) || $past(ev, 2) || $past(sys_rst))
    else $error("timeout or sleep flag moved by a write");
  AST_ALU_OVERRIDES_WRITE: assert property (
    wr_en && at_flags && alu_upd && alu_flag_sel[2] && !clear_op && !ev
    && !$past(power_up_rst) |=> flags[bcr_pkg::BIT_ZERO] == ($past(alu_result) == 8'h00))
    else $error("zero flag took written data");
  AST_CLEAR_FLAGS: assert property (
    clear_op && at_flags && !wr_en && !alu_upd && !ev && !$past(ev)
    |=> flags[7:5] == 3'h0 && flags[bcr_pkg::BIT_ZERO] && flags[1:0] == $past(flags[1:0]))
    else $error("clear of flags wrong");
  AST_UPPER_BUF_TO_PC: assert property (p_pc_upper)
    else $error("counter upper part not from buffer");
  AST_OTHER_RESET: assert property (
    (external_reset_pin || wdt_timeout) && !power_up_rst && !wr_en
    |-> ##[1:2] flags[7:5] == 3'h0 && prescale_opts == 8'hff) else $error("other reset");
  AST_POWER_RESET: assert property (
    power_up_rst |-> ##[1:2] flags == bcr_pkg::RST_FLAGS_POR) else $error("power reset");
  AST_SUB_NOT_BORROW: assert property (
    alu_upd && alu_sub && alu_flag_sel[0] && !clear_op && !ev && !$past(power_up_rst)
    |=> flags[0] == ($past(alu_a) >= $past(alu_b))) else $error("carry not inverted borrow");
endmodule // bcr_core_regs_chk
bind bcr_core_regs bcr_core_regs_chk u_chk (.*);

// [test/bcr_core_model.sv]
// partner model: processor core issuing register reads, writes and clears
`timescale 1ns/100ps
module bcr_core_model (
  input wire logic clk,
  output logic [6:0] operand,
  output logic [7:0] wr_data,
  output logic wr_en,
  output logic rd_en,
  output logic clear_op,
  input wire logic [7:0] rd_data
);
  initial begin
    operand = 7'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    clear_op = 1'b0;
  end
  // one slot, k is {clear, read, write}; request held through the taking edge
  task automatic op(input logic [6:0] o, input logic [7:0] v, input logic [2:0] k,
    output logic [7:0] q);
    operand = o;
    wr_data = k[0] ? v : ~wr_data; // value on writes, inverted previous data otherwise
    wr_en = k[0];
    rd_en = k[1];
    clear_op = k[2];
    #3 q = rd_data;
    @(posedge clk);
    #1;
  endtask
endmodule // bcr_core_model

// [test/tb_banked_core_register_file.sv]
// testbench: register access sequences against the banked core registers
`timescale 1ns/100ps
module tb_banked_core_register_file;
  logic clk, sys_rst, ext_rst, pwr_rst, wdt_to, wdt_clr, slp, ind;
  logic alu_upd, alu_sub, wr_en, rd_en, clear_op, rd_hit;
  logic [2:0] sel;
  logic [6:0] operand;
  logic [7:0] a, b, wr_data, rd_data, res, d, pins, latch, dir, opts, irq, flags;
  logic [8:0] idx;
  logic [12:0] pc;
  int fail_count = 0;
  int total_checks = 0;
  int i;
  bcr_core_model core (.clk(clk), .operand(operand), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .clear_op(clear_op), .rd_data(rd_data));
  bcr_core_regs dut (.clk(clk), .sys_rst(sys_rst), .external_reset_pin(ext_rst),
    .power_up_rst(pwr_rst), .wdt_timeout(wdt_to), .wdt_clear(wdt_clr), .sleep_enter(slp),
    .indirect(ind), .operand(operand), .rd_en(rd_en), .rd_data(rd_data), .rd_hit(rd_hit),
    .reg_index(idx), .wr_en(wr_en), .wr_data(wr_data), .clear_op(clear_op),
    .alu_upd(alu_upd), .alu_flag_sel(sel), .alu_sub(alu_sub), .alu_a(a), .alu_b(b),
    .alu_result(res), .pc_load(1'b0), .pc_load_value(13'h0000), .pc_step(1'b0), .pc(pc),
    .port_two_pins(pins), .timer_zero_in(8'h00), .timer_zero_tick(1'b0),
    .port_two_latch(latch), .port_two_dir(dir), .prescale_opts(opts), .irq_ctrl(irq),
    .flags(flags));
  // free-running core clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] o, input logic [7:0] v);
    core.op(o, v, 3'b001, d);
  endtask
  task automatic rd(input logic [6:0] o);
    core.op(o, 8'h00, 3'b010, d);
  endtask
  // idle slot: lets an edge pass so no strobe is raised twice at once
  task automatic idle;
    core.op(7'h00, 8'h00, 3'b000, d);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
    step(1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // guard against a hung sequence
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    $display("unexpected at %0t: run too long", $time);
    report_and_stop;
  end
  initial begin
    {sys_rst, ext_rst, pwr_rst, wdt_to, wdt_clr, slp, ind, alu_upd, alu_sub} = 9'h100;
    sel = 3'h0;
    a = 8'h00;
    b = 8'h00;
    pins = 8'h5a;
    repeat (6) @(posedge clk);
    #1 sys_rst = 1'b0;
    chk(flags, 8'h18);
    chk(opts, 8'hff);
    chk(dir, 8'hff);
    chk(latch, 8'h0c);
    chk(irq, 8'h00);
    chk(pc, 13'h0000);
    wr(7'h03, 8'h47);
    chk(flags, 8'h5f);
    rd(7'h05);
    chk(d, 8'h00);
    chk(idx, 9'h105);
    wr(7'h05, 8'haa);
    rd(7'h05);
    chk(d, 8'h00);
    rd(7'h06);
    chk(d, 8'h5a);
    $display("test map done");
    wr(7'h0a, 8'hff);
    wr(7'h02, 8'h34);
    chk(pc, 13'h1f34);
    rd(7'h0a);
    chk(d, 8'h1f);
    rd(7'h02);
    chk(d, 8'h34);
    for (i = 0; i < 4; i++) begin
      wr(7'h03, 8'(i << 5));
      rd(7'h0a);
      chk(d, 8'h1f);
      rd(7'h01);
      chk(d, (i == 3) ? 8'hff : 8'h00);
    end
    wr(7'h06, 8'h3c);
    wr(7'h04, 8'h86);
    wr(7'h03, 8'he0);
    ind = 1'b1;
    rd(7'h00);
    chk(d, 8'h3c);
    ind = 1'b0;
    $display("test banks done");
    // flag write while the alu claims all three result flags
    {alu_upd, sel, a, b} = {1'b1, 3'b111, 8'h80, 8'h80};
    wr(7'h03, 8'h60);
    chk(flags, 8'h7d);
    alu_sub = 1'b1;
    for (i = 0; i < 2; i++) begin
      a = i ? 8'h12 : 8'h10;
      b = 8'h01;
      idle;
      chk(res, 8'(a - b));
      chk(flags, i ? 8'h7b : 8'h79);
    end
    alu_upd = 1'b0;
    core.op(7'h03, 8'h00, 3'b100, d);
    chk(flags, 8'h1f);
    idle;
    pulse(slp);
    chk(flags, 8'h17);
    pulse(wdt_clr);
    chk(flags, 8'h1f);
    $display("test flags done");
    for (i = 0; i < 2; i++) begin
      wr(7'h03, 8'he2);
      wr(7'h01, 8'h00);
      wr(7'h0a, 8'h15);
      wr(7'h02, 8'h77);
      wr(7'h0b, 8'h81);
      chk(opts, 8'h00);
      chk(pc, 13'h1577);
      idle;
      if (i == 0) pulse(ext_rst);
      else pulse(wdt_to);
      step(2);
      chk(flags & 8'he7, 8'h02);
      chk(opts, 8'hff);
      chk(pc, 13'h0000);
      chk(irq, 8'h01);
      rd(7'h0a);
      chk(d, 8'h00);
    end
    idle;
    pulse(pwr_rst);
    step(2);
    chk(flags, 8'h18);
    $display("test resets done");
    report_and_stop;
  end
endmodule // tb_banked_core_register_file
